// File: rtl/dbsp_host.sv
// controller end of the link: clock divider, request fifo and burst sequencer
`timescale 1ns/1ns
`include "dbsp_cfg.svh"
module dbsp_host #(
   parameter int HALF_CNT   = `DBSP_HALF_CNT,
   parameter int MID_CNT    = `DBSP_MID_CNT,
   parameter int FIFO_DEPTH = `DBSP_FIFO_DEPTH
) (
   input  wire logic                     clk_sys,
   input  wire logic                     reset,
   dbsp_if.host                          link,
   input  wire logic                     req_valid,
   output logic                          req_ready,
   input  wire logic                     req_write,
   input  wire dbsp_pkg::dbsp_addr_type  req_addr,
   input  wire dbsp_pkg::dbsp_word_type  req_data0,
   input  wire dbsp_pkg::dbsp_word_type  req_data1,
   input  wire dbsp_pkg::dbsp_sel_type   req_sel0_n,
   input  wire dbsp_pkg::dbsp_sel_type   req_sel1_n,
   output logic                          rsp_valid,
   output dbsp_pkg::dbsp_word_type       rsp_data0,
   output dbsp_pkg::dbsp_word_type       rsp_data1
);
   localparam int REQ_W = $bits(dbsp_pkg::dbsp_req_type);

   dbsp_pkg::dbsp_req_type in_req;
   dbsp_pkg::dbsp_req_type head;
   dbsp_pkg::dbsp_req_type pres;
   dbsp_pkg::dbsp_req_type dat;
   dbsp_pkg::dbsp_op_type  pres_op;
   dbsp_pkg::dbsp_op_type  dat_op;
   logic [REQ_W-1:0]       head_bits;
   logic                   head_valid;
   logic                   pop;
   logic [7:0]             phase_cnt;
   logic                   tick_toggle;
   logic                   tick_mid;
   logic                   low_mid;
   logic                   high_mid;

   assign in_req = '{write: req_write, addr: req_addr, data0: req_data0, data1: req_data1,
                     sel0_n: req_sel0_n, sel1_n: req_sel1_n};
   assign head   = dbsp_pkg::dbsp_req_type'(head_bits);

   dbsp_fifo #(
      .WIDTH (REQ_W),
      .DEPTH (FIFO_DEPTH)
   ) u_req_fifo (
      .clk_sys (clk_sys),
      .reset   (reset),
      .s_valid (req_valid),
      .s_ready (req_ready),
      .s_data  (in_req),
      .m_valid (head_valid),
      .m_ready (pop),
      .m_data  (head_bits)
   );

   // divider: k toggles every HALF_CNT cycles, pins change mid-phase
   assign tick_toggle = (phase_cnt == 8'(HALF_CNT - 1));
   assign tick_mid    = (phase_cnt == 8'(MID_CNT));
   assign low_mid     = tick_mid & ~link.k;
   assign high_mid    = tick_mid & link.k;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         phase_cnt <= '0;
         link.k    <= 1'b0;
         link.k_n  <= 1'b1;
      end else if (tick_toggle) begin
         phase_cnt <= '0;
         link.k    <= ~link.k;
         link.k_n  <= link.k;
      end else begin
         phase_cnt <= phase_cnt + 8'h01;
      end
   end

   // a write straight after a read waits one slot so the buses never fight
   assign pop = low_mid & head_valid & ~(head.write & (pres_op == dbsp_pkg::dbsp_op_read));

   // command slot, presented in the low phase so it is stable at k rise
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pres                     <= '0;
         pres_op                  <= dbsp_pkg::dbsp_op_idle;
         dat                      <= '0;
         dat_op                   <= dbsp_pkg::dbsp_op_idle;
         link.transaction_valid_n <= 1'b1;
         link.dir_read            <= 1'b1;
         link.addr                <= `DBSP_ADDR_RESET;
      end else if (low_mid) begin
         dat    <= pres;
         dat_op <= pres_op;
         link.transaction_valid_n <= ~pop;
         if (pop) begin
            pres <= head;
            pres_op       <= head.write ? dbsp_pkg::dbsp_op_write : dbsp_pkg::dbsp_op_read;
            link.dir_read <= ~head.write;
            link.addr     <= head.addr;
         end else begin
            pres_op <= dbsp_pkg::dbsp_op_idle;
         end
      end
   end

   // write data slot: word0 before the next k rise, word1 before k_n rise
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         link.host_dq          <= `DBSP_WORD_RESET;
         link.host_dq_oe_n     <= 1'b1;
         link.byte_write_sel_n <= `DBSP_SEL_IDLE;
      end else if (low_mid) begin
         if (pres_op == dbsp_pkg::dbsp_op_write) begin
            link.host_dq          <= pres.data0;
            link.byte_write_sel_n <= pres.sel0_n;
            link.host_dq_oe_n     <= 1'b0;
         end else begin
            link.host_dq_oe_n     <= 1'b1;
            link.byte_write_sel_n <= `DBSP_SEL_IDLE;
         end
      end else if (high_mid && dat_op == dbsp_pkg::dbsp_op_write) begin
         link.host_dq          <= dat.data1;
         link.byte_write_sel_n <= dat.sel1_n;
      end
   end

   // read capture mid-phase, after the device has settled each word
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rsp_valid <= 1'b0;
         rsp_data0 <= `DBSP_WORD_RESET;
         rsp_data1 <= `DBSP_WORD_RESET;
      end else begin
         rsp_valid <= low_mid & (dat_op == dbsp_pkg::dbsp_op_read);
         if (high_mid && dat_op == dbsp_pkg::dbsp_op_read) begin
            rsp_data0 <= link.dq;
         end
         if (low_mid && dat_op == dbsp_pkg::dbsp_op_read) begin
            rsp_data1 <= link.dq;
         end
      end
   end
endmodule : dbsp_host

// File: rtl/dbsp_cfg.svh
// constants for the double-data-rate burst sram port and its controller
`ifndef DBSP_CFG_SVH
`define DBSP_CFG_SVH

`define DBSP_DATA_W      36
`define DBSP_ADDR_W      21
`define DBSP_LANES       4
`define DBSP_LANE_W      9
`define DBSP_BURST_LEN   2
`define DBSP_HALF_CNT    4
`define DBSP_MID_CNT     1
`define DBSP_FIFO_DEPTH  16
`define DBSP_WORD_RESET  36'h0_0000_0000
`define DBSP_ADDR_RESET  21'h00_0000
`define DBSP_SEL_IDLE    4'hF

`endif

// File: rtl/dbsp_pkg.sv
// shared types and the byte merge function of the burst sram port
`include "dbsp_cfg.svh"
package dbsp_pkg;

   typedef logic [`DBSP_DATA_W-1:0] dbsp_word_type;
   typedef logic [`DBSP_ADDR_W-1:0] dbsp_addr_type;
   typedef logic [`DBSP_LANES-1:0]  dbsp_sel_type;

   typedef enum logic [1:0] {dbsp_op_idle, dbsp_op_read, dbsp_op_write} dbsp_op_type;

   typedef struct packed {
      logic          write;
      dbsp_addr_type addr;
      dbsp_word_type data0;
      dbsp_word_type data1;
      dbsp_sel_type  sel0_n;
      dbsp_sel_type  sel1_n;
   } dbsp_req_type;

   // lane i covers bits [9i+8:9i]; a high select keeps the old byte
   function automatic dbsp_word_type merge_bytes(input dbsp_word_type old_word,
                                                 input dbsp_word_type new_word,
                                                 input dbsp_sel_type  sel_n);
      dbsp_word_type res;
      res = old_word;
      for (int i = 0; i < `DBSP_LANES; i++) begin
         if (!sel_n[i]) begin
            res[i*`DBSP_LANE_W +: `DBSP_LANE_W] = new_word[i*`DBSP_LANE_W +: `DBSP_LANE_W];
         end
      end
      return res;
   endfunction : merge_bytes

endpackage : dbsp_pkg

// File: rtl/dbsp_if.sv
// pin bundle between the memory controller and the sram port
`timescale 1ns/1ns
interface dbsp_if;
   logic                    k;
   logic                    k_n;
   logic                    transaction_valid_n;
   logic                    dir_read;
   dbsp_pkg::dbsp_addr_type addr;
   dbsp_pkg::dbsp_sel_type  byte_write_sel_n;
   dbsp_pkg::dbsp_word_type host_dq;
   logic                    host_dq_oe_n;
   dbsp_pkg::dbsp_word_type dev_dq;
   logic                    dev_dq_oe_n;
   dbsp_pkg::dbsp_word_type dq;

   // resolved data wire; an undriven bus reads as zero
   assign dq = !dev_dq_oe_n  ? dev_dq  :
               !host_dq_oe_n ? host_dq : '0;

   modport dev  (input  k, k_n, transaction_valid_n, dir_read, addr, byte_write_sel_n, dq,
                 output dev_dq, dev_dq_oe_n);
   modport host (output k, k_n, transaction_valid_n, dir_read, addr, byte_write_sel_n,
                 host_dq, host_dq_oe_n,
                 input  dq);
endinterface : dbsp_if

// File: rtl/dbsp_fifo.sv
// request fifo with valid and ready on both sides
`timescale 1ns/1ns
`include "dbsp_cfg.svh"
module dbsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `DBSP_FIFO_DEPTH
) (
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic             s_valid,
   output logic                  s_ready,
   input  wire logic [WIDTH-1:0] s_data,
   output logic                  m_valid,
   input  wire logic             m_ready,
   output logic [WIDTH-1:0]      m_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] ptr);
      return (ptr == AW'(DEPTH - 1)) ? '0 : AW'(ptr + 1'b1);
   endfunction : next_ptr

   // handshakes on both sides
   assign push       = s_valid & s_ready;
   assign pop        = m_valid & m_ready;
   assign m_valid    = (count != '0);
   assign m_data     = store[rd_ptr];
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

   // storage has no reset, only pointers, count and ready do
   always_ff @(posedge clk_sys) begin
      if (push) begin
         store[wr_ptr] <= s_data;
      end
   end

   // pointers, fill level and a registered ready that is honest about full
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wr_ptr  <= '0;
         rd_ptr  <= '0;
         count   <= '0;
         s_ready <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr <= next_ptr(wr_ptr);
         end
         if (pop) begin
            rd_ptr <= next_ptr(rd_ptr);
         end
         count   <= next_count;
         s_ready <= (next_count != (AW+1)'(DEPTH));
      end
   end
endmodule : dbsp_fifo

// File: rtl/dbsp_device.sv
// sram end of the link: command capture, two-word bursts and storage
`timescale 1ns/1ns
`include "dbsp_cfg.svh"
module dbsp_device #(
   parameter int MEM_AW = `DBSP_ADDR_W
) (
   input  wire logic               clk_sys,
   input  wire logic               reset,
   dbsp_if.dev                     link,
   output logic                    acc_strobe,
   output logic                    acc_write,
   output dbsp_pkg::dbsp_addr_type acc_addr
);
   // two banks: even holds word0, odd holds the companion word1
   // two arrays of 2M words
   dbsp_pkg::dbsp_word_type mem_even [2**MEM_AW];
   dbsp_pkg::dbsp_word_type mem_odd  [2**MEM_AW];

   logic                    k_q;
   logic                    kn_q;
   logic                    k_rise;
   logic                    kn_rise;
   logic                    pend_rd;
   logic                    pend_wr;
   dbsp_pkg::dbsp_addr_type pend_addr;
   logic                    cur_rd;
   logic                    cur_wr;
   dbsp_pkg::dbsp_addr_type cur_addr;
   logic [MEM_AW-1:0]       pend_idx;
   logic [MEM_AW-1:0]       cur_idx;

   // link clocks come from logic on clk_sys, so edges are found directly
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         k_q  <= 1'b0;
         kn_q <= 1'b1;
      end else begin
         k_q  <= link.k;
         kn_q <= link.k_n;
      end
   end

   assign k_rise   = link.k & ~k_q;
   assign kn_rise  = link.k_n & ~kn_q;
   assign pend_idx = pend_addr[MEM_AW-1:0];
   assign cur_idx  = cur_addr[MEM_AW-1:0];

   // command pipeline: loaded on one k rise, data moves one k period later
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pend_rd   <= 1'b0;
         pend_wr   <= 1'b0;
         pend_addr <= `DBSP_ADDR_RESET;
         cur_rd    <= 1'b0;
         cur_wr    <= 1'b0;
         cur_addr  <= `DBSP_ADDR_RESET;
      end else if (k_rise) begin
         // strobe looked at on every k rise
         pend_rd   <= ~link.transaction_valid_n & link.dir_read;
         pend_wr   <= ~link.transaction_valid_n & ~link.dir_read;
         pend_addr <= link.addr;
         // burst always runs its second half
         cur_rd    <= pend_rd;
         cur_wr    <= pend_wr;
         cur_addr  <= pend_addr;
      end
   end

   // writes merge per lane, so no write can touch a deselected byte
   always_ff @(posedge clk_sys) begin
      if (k_rise && pend_wr) begin
         mem_even[pend_idx] <= dbsp_pkg::merge_bytes(mem_even[pend_idx], link.dq,
                                                     link.byte_write_sel_n);
      end
      if (kn_rise && cur_wr) begin
         mem_odd[cur_idx] <= dbsp_pkg::merge_bytes(mem_odd[cur_idx], link.dq,
                                                   link.byte_write_sel_n);
      end
   end

   // read drive; the enable falls away on the next k rise without a read
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         link.dev_dq      <= `DBSP_WORD_RESET;
         link.dev_dq_oe_n <= 1'b1;
      end else if (k_rise) begin
         // tristate unless a read is due
         if (pend_rd) begin
            link.dev_dq      <= mem_even[pend_idx];
            link.dev_dq_oe_n <= 1'b0;
         end else begin
            link.dev_dq_oe_n <= 1'b1;
         end
      end else if (kn_rise && cur_rd) begin
         link.dev_dq <= mem_odd[cur_idx];
      end
   end

   // access report for the user side, one pulse per accepted command
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         acc_strobe <= 1'b0;
         acc_write  <= 1'b0;
         acc_addr   <= `DBSP_ADDR_RESET;
      end else begin
         acc_strobe <= k_rise & ~link.transaction_valid_n;
         if (k_rise && !link.transaction_valid_n) begin
            acc_write <= ~link.dir_read;
            acc_addr  <= link.addr;
         end
      end
   end
endmodule : dbsp_device

// File: bench/dbsp_chk.sv
// pin rules between the sram port and its controller
`timescale 1ns/1ns
module dbsp_chk (
   input wire logic                    clk_sys,
   input wire logic                    reset,
   input wire logic                    k,
   input wire logic                    transaction_valid_n,
   input wire logic                    dir_read,
   input wire dbsp_pkg::dbsp_addr_type addr,
   input wire dbsp_pkg::dbsp_sel_type  byte_write_sel_n,
   input wire logic                    host_dq_oe_n,
   input wire logic                    dev_dq_oe_n,
   input wire logic                    acc_strobe,
   input wire logic                    acc_write,
   input wire dbsp_pkg::dbsp_addr_type acc_addr
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   logic [4:0] rd_age;

   // cycles since the last loaded read; saturates so idle stays far away
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rd_age <= 5'h1F;
      end else if ($rose(k) && !transaction_valid_n && dir_read) begin
         rd_age <= 5'h00;
      end else if (rd_age != 5'h1F) begin
         rd_age <= rd_age + 5'h01;
      end
   end

   sequence s_load;
      $rose(k) && !transaction_valid_n;
   endsequence
   sequence s_rd;
      $rose(k) && !transaction_valid_n && dir_read;
   endsequence
   sequence s_wr;
      $rose(k) && !transaction_valid_n && !dir_read;
   endsequence

   AST_LOAD_TAKEN: assert property (s_load |-> ##[1:2]
      (acc_strobe && acc_addr == addr && acc_write == !dir_read))
      else $error("loaded command not taken with its address and direction");
   AST_IDLE_NOLOAD: assert property ($rose(k) && transaction_valid_n |->
      ##1 !acc_strobe ##1 !acc_strobe) else $error("command taken with strobe high");
   AST_STROBE_PERIOD: assert property ($fell(transaction_valid_n) |->
      !transaction_valid_n [*8]) else $error("load strobe shorter than a link period");
   AST_READ_DRIVE: assert property (s_rd |-> ##[7:10] !dev_dq_oe_n)
      else $error("read data not driven");
   AST_READ_BURST: assert property ($fell(dev_dq_oe_n) |-> !dev_dq_oe_n [*8])
      else $error("read burst cut short");
   AST_AUTO_TRISTATE: assert property (!dev_dq_oe_n |-> rd_age <= 5'h14)
      else $error("device drives data without a read");
   AST_ONE_DRIVER: assert property (!(!dev_dq_oe_n && !host_dq_oe_n))
      else $error("both ends drive the data bus");
   AST_WRITE_DATA: assert property (s_wr |-> ##[1:8] !host_dq_oe_n)
      else $error("write data not presented");
   AST_SEL_IDLE: assert property (host_dq_oe_n |-> byte_write_sel_n == 4'hF)
      else $error("lane selects active without write data");
endmodule : dbsp_chk

// File: bench/tb_top.sv
// self-checking bench joining controller and sram port across the pin bundle
`timescale 1ns/1ns
module tb_top;
   logic                    clk_sys, reset, req_valid, req_ready, req_write, rsp_valid;
   logic                    acc_strobe, acc_write;
   dbsp_pkg::dbsp_addr_type req_addr, acc_addr;
   dbsp_pkg::dbsp_word_type req_data0, req_data1, rsp_data0, rsp_data1;
   dbsp_pkg::dbsp_sel_type  req_sel0_n, req_sel1_n;
   dbsp_pkg::dbsp_word_type mem0 [64], mem1 [64], ex0 [$], ex1 [$], got0 [$], got1 [$];
   int                      failures, compares, cycles, n_acc, n_cmd;
   logic                    saw_full;

   dbsp_if dbsp_if_i ();
   // small memory keeps the two banks cheap in simulation
   dbsp_device #(.MEM_AW(6)) dbsp_device_i (.clk_sys(clk_sys), .reset(reset),
      .link(dbsp_if_i), .acc_strobe(acc_strobe), .acc_write(acc_write), .acc_addr(acc_addr));
   dbsp_host #(.HALF_CNT(4), .MID_CNT(1), .FIFO_DEPTH(16)) dbsp_host_i (.clk_sys(clk_sys),
      .reset(reset), .link(dbsp_if_i), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_addr(req_addr), .req_data0(req_data0),
      .req_data1(req_data1), .req_sel0_n(req_sel0_n), .req_sel1_n(req_sel1_n),
      .rsp_valid(rsp_valid), .rsp_data0(rsp_data0), .rsp_data1(rsp_data1));
   dbsp_chk dbsp_chk_i (.clk_sys(clk_sys), .reset(reset), .k(dbsp_if_i.k),
      .transaction_valid_n(dbsp_if_i.transaction_valid_n), .dir_read(dbsp_if_i.dir_read),
      .addr(dbsp_if_i.addr), .byte_write_sel_n(dbsp_if_i.byte_write_sel_n),
      .host_dq_oe_n(dbsp_if_i.host_dq_oe_n), .dev_dq_oe_n(dbsp_if_i.dev_dq_oe_n),
      .acc_strobe(acc_strobe), .acc_write(acc_write), .acc_addr(acc_addr));

   always #5 clk_sys = ~clk_sys;

   // own lane merge so expectations stay independent of the design
   function automatic dbsp_pkg::dbsp_word_type lanes(input dbsp_pkg::dbsp_word_type o,
      input dbsp_pkg::dbsp_word_type n, input dbsp_pkg::dbsp_sel_type s);
      for (int i = 0; i < 4; i++) begin
         if (s[i] === 1'b0) o[9*i +: 9] = n[9*i +: 9];
      end
      return o;
   endfunction : lanes

   task automatic chk(input string name, input dbsp_pkg::dbsp_word_type seen,
      input dbsp_pkg::dbsp_word_type exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic results();
      $display("counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results

   // called at a falling edge; valid stays up so back to back pushes never glitch
   task automatic push(input logic w, input int a, input dbsp_pkg::dbsp_word_type d0,
      input dbsp_pkg::dbsp_word_type d1, input dbsp_pkg::dbsp_sel_type s0,
      input dbsp_pkg::dbsp_sel_type s1);
      req_valid = 1'b1;
      req_write = w;
      req_addr = dbsp_pkg::dbsp_addr_type'(a);
      req_data0 = d0;
      req_data1 = d1;
      req_sel0_n = s0;
      req_sel1_n = s1;
      n_cmd++;
      if (w) begin
         mem0[a] = lanes(mem0[a], d0, s0);
         mem1[a] = lanes(mem1[a], d1, s1);
      end else begin
         ex0.push_back(mem0[a]);
         ex1.push_back(mem1[a]);
      end
      while (req_ready !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
   endtask : push

   task automatic drain(input string name);
      req_valid = 1'b0;
      for (int i = 0; i < 3000 && (got0.size() < ex0.size() || n_acc < n_cmd); i++)
         @(negedge clk_sys);
      chk("read burst count", got0.size(), ex0.size());
      chk("accepted commands", n_acc, n_cmd);
      while (ex0.size() > 0 && got0.size() > 0) begin
         chk("word0", got0.pop_front(), ex0.pop_front());
         chk("word1", got1.pop_front(), ex1.pop_front());
      end
      $display("test %s done", name);
   endtask : drain

   // responses, accepted commands and refusals seen where outputs are settled
   always @(negedge clk_sys) begin
      if (rsp_valid === 1'b1) begin
         got0.push_back(rsp_data0);
         got1.push_back(rsp_data1);
      end
      if (acc_strobe === 1'b1) n_acc++;
      if (reset === 1'b0 && req_ready === 1'b0) saw_full = 1'b1;
   end

   // a hang counts as a mismatch and ends the run
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         results();
      end
   end

   initial begin
      clk_sys = 1'b0;
      reset = 1'b1;
      saw_full = 1'b0;
      // queue stays idle while reset is held
      req_valid = 1'b0;
      repeat (5) @(negedge clk_sys);
      reset = 1'b0;
      // back to back writes, reads, and a write right behind a read
      for (int a = 0; a < 4; a++) push(1'b1, a, 36'h1_0000_0000 + a, 36'hA_5A5A_5A50 + a,
         4'h0, 4'h0);
      for (int a = 0; a < 4; a++) push(1'b0, a, 36'h0, 36'h0, 4'hF, 4'hF);
      push(1'b1, 0, 36'h0_1234_5678, 36'h8_7654_3210, 4'h0, 4'h0);
      push(1'b0, 0, 36'h0, 36'h0, 4'hF, 4'hF);
      drain("basic");
      // one lane per word, different lanes in the two halves of the burst
      for (int i = 0; i < 4; i++) begin
         push(1'b1, 8 + i, 36'hF_FFFF_FFFF, 36'hF_FFFF_FFFF, 4'h0, 4'h0);
         push(1'b1, 8 + i, 36'h0, 36'h0, ~(4'h1 << i), ~(4'h8 >> i));
         push(1'b0, 8 + i, 36'h0, 36'h0, 4'hF, 4'hF);
      end
      drain("lanes");
      // pushes every cycle outrun the link until the queue refuses
      for (int a = 0; a < 20; a++) push(1'b1, 16 + a, 36'h3_0000_0000 + a, a, 4'h0, 4'h0);
      push(1'b0, 35, 36'h0, 36'h0, 4'hF, 4'hF);
      drain("fill");
      chk("queue refused", saw_full, 1'b1);
      results();
   end
endmodule : tb_top
